/* File: core/odbc_device.sv */
// sensor end: control register, decimation, address pointer, burst drain
// assumes serial engines deliver byte strobes on the link; idr_tick from timebase
// Notes on behaviour
// - fifo, motion, outputs, interrupts use output rate
// - decimation off at reset, any internal rate
// - code zero: output rate equals internal rate
// - codes 1-7 divide by 2..20
// - codes 8-15 divide by 40..1000
// - wrap bit clear: pointer wraps at end
// - wrap bit set: pointer increments linearly
// - end select clear: 0x12 wraps to 0x0d
// - end select set: 0x14 wraps to 0x0d
// - host writes reserved bit six as zero
// - no burst: one read gives one sample
// - burst: one read drains up to 32
// - host sets read count before burst
// - host sets burst for multi-sample reads
// - host may skip burst for single sample
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module odbc_device
  import odbc_pkg::*;
#(
  parameter int MAX_BURST = ODBC_MAX_BURST  // most samples that one burst read drains
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  odbc_if.dev       lnk,
  input  wire logic idr_tick,     // internal-rate enable from timebase
  output logic      odr_tick,     // update enable for fifo/motion/outputs/irq
  output logic      decim_active,
  output logic      burst_mode,
  output logic      read_active
);

  /////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the sample counter is six bits, and a burst of one sample is single mode
  if (MAX_BURST < 2 || MAX_BURST > 64) begin : g_bad_max_burst
    $error("odbc_device: MAX_BURST must lie in 2..64");
  end

  // the byte counter is three bits
  if (ODBC_SAMPLE_BYTES < 2 || ODBC_SAMPLE_BYTES > 8) begin : g_bad_sample_bytes
    $error("odbc_device: sample length must lie in 2..8 bytes");
  end

  // the wrap window must run upwards from the x axis low byte
  if (ODBC_ADDR_Z_HIGH <= ODBC_ADDR_X_LOW ||
      ODBC_ADDR_INT_FLG <= ODBC_ADDR_Z_HIGH) begin : g_bad_window
    $error("odbc_device: wrap end addresses must lie above the start address");
  end

  /////////////////////////////////////////////////////////////////////////////
  // state

  localparam logic [2:0] LAST_BYTE = 3'(ODBC_SAMPLE_BYTES - 1);
  // seven bits, so that a cap of 64 is not cut to zero
  localparam logic [6:0] BURST_CAP = 7'(MAX_BURST);

  typedef struct packed {
    logic [7:0] ctrl;      // burst_decimation_control
    logic [7:0] ptr;       // register address pointer
    logic       active;    // a read cycle is in progress
    logic [2:0] byte_cnt;  // byte position inside the current sample
    logic [5:0] samples;   // samples finished in this read
    logic       pop;       // one-cycle sample pop
  } odbc_dev_s;

  localparam odbc_dev_s DEV_RESET = '{
    ctrl:     ODBC_REG_RESET,
    ptr:      8'h00,
    active:   1'b0,
    byte_cnt: 3'd0,
    samples:  6'd0,
    pop:      1'b0
  };

  odbc_dev_s r;
  odbc_dev_s next_r;

  /////////////////////////////////////////////////////////////////////////////
  // helpers

  // reserved bit kept low whatever the host sends
  function automatic logic [7:0] clean_ctrl(
    input logic [7:0] value
  );
    clean_ctrl = value & ~(8'h01 << ODBC_RESV_BIT);
  endfunction : clean_ctrl

  // code zero leaves the output rate equal to the internal rate
  function automatic logic is_decimating(
    input logic [3:0] code
  );
    is_decimating = (code != 4'h0);
  endfunction : is_decimating

  // last address before the pointer folds back to the x axis low byte
  function automatic logic [7:0] wrap_end(
    input logic [7:0] ctrl
  );
    if (ctrl[ODBC_WRAP_SEL_BIT]) begin
      wrap_end = ODBC_ADDR_INT_FLG;
    end else begin
      wrap_end = ODBC_ADDR_Z_HIGH;
    end
  endfunction : wrap_end

  // pointer after one byte has left the device
  function automatic logic [7:0] step_ptr(
    input logic [7:0] ptr,
    input logic [7:0] ctrl
  );
    if (ctrl[ODBC_WRAP_N_BIT]) begin
      step_ptr = ptr + 8'h01;
    end else if (ptr == wrap_end(ctrl)) begin
      step_ptr = ODBC_ADDR_X_LOW;
    end else begin
      step_ptr = ptr + 8'h01;
    end
  endfunction : step_ptr

  // true when the sample just finished closes the read cycle;
  // a read count of zero or one still drains one sample, never none
  function automatic logic read_done(
    input logic       burst,
    input logic [5:0] done_before,
    input logic [5:0] wanted
  );
    logic [6:0] finished;
    finished = {1'b0, done_before} + 7'd1;
    if (!burst) begin
      read_done = 1'b1;
    end else begin
      read_done = (finished >= {1'b0, wanted}) || (finished >= BURST_CAP);
    end
  endfunction : read_done

  /////////////////////////////////////////////////////////////////////////////
  // output-rate divider

  // only the update enable slows down; converter and filter keep the internal rate
  odbc_divider u_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .code     (r.ctrl[3:0]),
    .idr_tick (idr_tick),
    .odr_tick (odr_tick)
  );

  /////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r     = r;
    next_r.pop = 1'b0;

    // control register write from the host
    if (lnk.wr_valid) begin
      next_r.ctrl = clean_ctrl(lnk.wr_data);
    end

    // read cycle: load the pointer, then step it once per byte taken
    if (lnk.rd_start) begin
      next_r.active   = 1'b1;
      next_r.ptr      = lnk.rd_addr;
      next_r.byte_cnt = 3'd0;
      next_r.samples  = 6'd0;
    end else if (r.active && lnk.rd_next) begin
      next_r.ptr = step_ptr(r.ptr, r.ctrl);
      if (r.byte_cnt == LAST_BYTE) begin
        // sample complete: hand it on and decide whether the read goes on
        next_r.byte_cnt = 3'd0;
        next_r.pop      = 1'b1;
        next_r.samples  = r.samples + 6'd1;
        if (read_done(r.ctrl[ODBC_BURST_BIT], r.samples, lnk.burst_cnt)) begin
          next_r.active = 1'b0;
        end
      end else begin
        next_r.byte_cnt = r.byte_cnt + 3'd1;
      end
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // registers

  // reset clears everything at once, decimation included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // outputs

  assign lnk.ctrl_q     = r.ctrl;
  assign lnk.ptr        = r.ptr;
  assign lnk.sample_pop = r.pop;
  assign decim_active   = is_decimating(r.ctrl[3:0]);
  assign burst_mode     = r.ctrl[ODBC_BURST_BIT];
  assign read_active    = r.active;

endmodule : odbc_device

/* File: core/odbc_divider.sv */
// output-rate divider: one odr pulse per ratio internal-rate pulses
// assumes idr_tick is a one-cycle enable from the timebase
`timescale 1ns/1ps
module odbc_divider
  import odbc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] code,
  input  wire logic       idr_tick,
  output logic            odr_tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic [3:0] code_q;
    logic       tick;
  } odbc_div_s;
  odbc_div_s r, next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    next_r.code_q = code;
    if (code != r.code_q) begin
      next_r.cnt = 10'd0;
    end else if (idr_tick) begin
      if (r.cnt + 10'd1 >= odbc_ratio(code)) begin
        next_r.cnt  = 10'd0;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 10'd1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign odr_tick = r.tick;
endmodule : odbc_divider

/* File: core/odbc_host.sv */
// host end: AHB-Lite slave with command registers driving the link
// assumes single word transfers, single master
`timescale 1ns/1ps
module odbc_host
  import odbc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        byte_taken,   // serial engine moved one byte
  odbc_if.host             lnk
);
  typedef struct packed {
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic       wr_valid;
    logic [7:0] wr_data;
    logic [5:0] count;
    logic       rd_start;
  } odbc_host_s;
  odbc_host_s r, next_r;
  logic       take;

  // only whole-word transfers are served; anything narrower is ignored
  assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb begin
    next_r          = r;
    next_r.wr_valid = 1'b0;
    next_r.rd_start = 1'b0;
    next_r.ph_wr    = take && hwrite;
    next_r.ph_rd    = take && !hwrite;
    if (take) begin
      next_r.ph_addr = haddr;
    end
    if (r.ph_wr) begin
      case (r.ph_addr)
        ODBC_H_CTRL: begin
          next_r.wr_data = hwdata[7:0] & ~(8'h01 << ODBC_RESV_BIT);
          next_r.wr_valid = hwdata[8];
          next_r.rd_start = hwdata[9];
        end
        ODBC_H_COUNT: next_r.count = hwdata[5:0];
        default: ;
      endcase
    end
    if (take && !hwrite) begin
      case (haddr)
        ODBC_H_CTRL:   next_r.rdata = {24'h0, lnk.ctrl_q};
        ODBC_H_STATUS: next_r.rdata = {16'h0, lnk.ptr, 7'h0, lnk.sample_pop};
        ODBC_H_COUNT:  next_r.rdata = {26'h0, r.count};
        default:       next_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata        = r.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign lnk.wr_valid  = r.wr_valid;
  assign lnk.wr_data   = r.wr_data;
  assign lnk.rd_start  = r.rd_start;
  assign lnk.rd_addr   = ODBC_ADDR_X_LOW;
  assign lnk.rd_next   = byte_taken;
  assign lnk.burst_cnt = r.count;
endmodule : odbc_host

/* File: core/odbc_if.sv */
// link between sensor control logic and host controller
// assumes both ends on the same hclk
`timescale 1ns/1ps
interface odbc_if;
  logic       wr_valid;   // host writes the control register
  logic [7:0] wr_data;
  logic [7:0] ctrl_q;     // control register readback
  logic       rd_start;   // pulse: begin a read at rd_addr
  logic [7:0] rd_addr;
  logic       rd_next;    // pulse: host took one byte
  logic [7:0] ptr;        // current register address pointer
  logic       sample_pop; // pulse: one six-byte sample leaves the fifo
  logic [5:0] burst_cnt;  // samples to drain (read-count value)
  modport dev  (input wr_valid, wr_data, rd_start, rd_addr, rd_next, burst_cnt,
                output ctrl_q, ptr, sample_pop);
  modport host (output wr_valid, wr_data, rd_start, rd_addr, rd_next, burst_cnt,
                input ctrl_q, ptr, sample_pop);
endinterface : odbc_if

/* File: core/odbc_pkg.sv */
// package for the decimation / pointer-wrap / burst control block
// assumes one 100 MHz clock shared by both ends
package odbc_pkg;
  localparam logic [7:0] ODBC_REG_OFFSET   = 8'h30;  // burst_decimation_control
  localparam logic [7:0] ODBC_REG_RESET    = 8'h00;
  localparam int         ODBC_CODE_LSB     = 0;
  localparam int         ODBC_WRAP_N_BIT   = 4;
  localparam int         ODBC_WRAP_SEL_BIT = 5;
  localparam int         ODBC_RESV_BIT     = 6;
  localparam int         ODBC_BURST_BIT    = 7;
  localparam logic [7:0] ODBC_ADDR_X_LOW   = 8'h0d;  // x_axis_low_byte
  localparam logic [7:0] ODBC_ADDR_Z_HIGH  = 8'h12;
  localparam logic [7:0] ODBC_ADDR_INT_FLG = 8'h14;  // accel_int_flags
  localparam logic [7:0] ODBC_READ_COUNT   = 8'h4b;
  localparam int         ODBC_SAMPLE_BYTES = 6;
  localparam int         ODBC_MAX_BURST    = 32;
  // host-side command registers (AHB-Lite word addresses)
  localparam logic [7:0] ODBC_H_CTRL   = 8'h00;  // [7:0] value, bit8 write, bit9 start read
  localparam logic [7:0] ODBC_H_STATUS = 8'h04;  // bit0 sample pop, [15:8] pointer
  localparam logic [7:0] ODBC_H_COUNT  = 8'h08;  // samples to drain per burst

  typedef enum logic [1:0] {ODBC_OP_NONE, ODBC_OP_WRITE, ODBC_OP_READ} odbc_op_e;

  // divide ratio per rate_divide_code; 1 means output_rate equals internal_rate
  function automatic logic [9:0] odbc_ratio(input logic [3:0] code);
    case (code)
      4'h1: odbc_ratio = 10'd2;    4'h2: odbc_ratio = 10'd4;
      4'h3: odbc_ratio = 10'd5;    4'h4: odbc_ratio = 10'd8;
      4'h5: odbc_ratio = 10'd10;   4'h6: odbc_ratio = 10'd16;
      4'h7: odbc_ratio = 10'd20;   4'h8: odbc_ratio = 10'd40;
      4'h9: odbc_ratio = 10'd67;   4'ha: odbc_ratio = 10'd80;
      4'hb: odbc_ratio = 10'd100;  4'hc: odbc_ratio = 10'd200;
      4'hd: odbc_ratio = 10'd250;  4'he: odbc_ratio = 10'd500;
      4'hf: odbc_ratio = 10'd1000;
      default: odbc_ratio = 10'd1;
    endcase
  endfunction : odbc_ratio
endpackage : odbc_pkg

/* File: testbench/odbc_assertions.sv */
// checker for the link between sensor control logic and host controller
// assumes one hclk domain; inputs are the link signals, wired by the bench
`timescale 1ns/1ps
module odbc_assertions (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] ctrl_q,
  input wire logic       rd_start,
  input wire logic [7:0] rd_addr,
  input wire logic       rd_next,
  input wire logic [7:0] ptr,
  input wire logic       sample_pop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // byte position inside the current six-byte sample
  logic [2:0] byte_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) byte_cnt <= 3'h0;
    else if (rd_start) byte_cnt <= 3'h0;
    else if (rd_next) byte_cnt <= (byte_cnt == 3'h5) ? 3'h0 : byte_cnt + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_sixth;
    rd_next && byte_cnt == 3'h5;
  endsequence
  sequence s_plain_step;
    rd_next && !ctrl_q[4] && ptr != 8'h12 && ptr != 8'h14;
  endsequence
  property p_reset;
    $rose(hresetn) |-> ctrl_q == 8'h00;
  endproperty
  property p_write;
    wr_valid |=> ctrl_q == ($past(wr_data) & 8'hbf);
  endproperty
  property p_hold;
    !wr_valid |=> $stable(ctrl_q);
  endproperty
  property p_start;
    rd_start |=> ptr == $past(rd_addr);
  endproperty
  property p_linear;
    rd_next && ctrl_q[4] |=> ptr == $past(ptr) + 8'h01;
  endproperty
  property p_step;
    s_plain_step |=> ptr == $past(ptr) + 8'h01;
  endproperty
  property p_wrap_low;
    rd_next && ctrl_q[5:4] == 2'b00 && ptr == 8'h12 |=> ptr == 8'h0d;
  endproperty
  property p_wrap_high;
    rd_next && ctrl_q[5:4] == 2'b10 && ptr == 8'h14 |=> ptr == 8'h0d;
  endproperty
  property p_pop;
    s_sixth |=> sample_pop;
  endproperty
  property p_pop_only;
    sample_pop |-> $past(rd_next) && $past(byte_cnt) == 3'h5;
  endproperty
  a_reset:     assert property (p_reset) else $error("control not clear after reset");
  a_write:     assert property (p_write) else $error("control write wrong");
  a_hold:      assert property (p_hold) else $error("control changed without write");
  a_start:     assert property (p_start) else $error("pointer not loaded at start");
  a_linear:    assert property (p_linear) else $error("linear step wrong");
  a_step:      assert property (p_step) else $error("pointer step wrong");
  a_wrap_low:  assert property (p_wrap_low) else $error("low wrap wrong");
  a_wrap_high: assert property (p_wrap_high) else $error("high wrap wrong");
  a_pop:       assert property (p_pop) else $error("sample pop missing");
  a_pop_only:  assert property (p_pop_only) else $error("stray sample pop");
endmodule : odbc_assertions

/* File: testbench/tb_top.sv */
// self-checking bench: host and device ends joined by the link interface
// assumes the core/ files are compiled first; software side is an AHB-Lite master
`timescale 1ns/1ps
module tb_top;
  import odbc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        byte_taken = 1'b0, idr_tick = 1'b0;
  logic [7:0]  haddr = 8'h00, p;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic        hreadyout, hresp, odr_tick, decim_active, burst_mode, read_active;
  int          mismatches = 0, comparisons = 0, n, pops;
  int          ratio [16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 100, 200, 250, 500, 1000};
  // rows: control value, burst count, bytes taken, samples expected
  logic [31:0] rows [6] = '{32'h00_00_06_01, 32'h80_02_0c_02, 32'h90_02_0c_02,
                            32'ha0_02_0c_02, 32'hb0_03_12_03, 32'hc0_20_c0_20};
  odbc_if lnk ();
  odbc_host i_odbc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .byte_taken(byte_taken),
    .lnk(lnk.host));
  odbc_device i_odbc_device (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev), .idr_tick(idr_tick),
    .odr_tick(odr_tick), .decim_active(decim_active), .burst_mode(burst_mode),
    .read_active(read_active));
  odbc_assertions i_odbc_assertions (.hclk(hclk), .hresetn(hresetn), .wr_valid(lnk.wr_valid),
    .wr_data(lnk.wr_data), .ctrl_q(lnk.ctrl_q), .rd_start(lnk.rd_start), .rd_addr(lnk.rd_addr),
    .rd_next(lnk.rd_next), .ptr(lnk.ptr), .sample_pop(lnk.sample_pop));
  always #5 hclk = ~hclk;
  // internal rate every second cycle, so one output period is twice the ratio
  always @(posedge hclk) idr_tick <= ~idr_tick;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    // start on a rising edge so every change lands just after it
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic setctrl(input logic [7:0] v);
    ahb(ODBC_H_CTRL, 1'b1, {23'h0, 1'b1, v});
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("control", 32'(lnk.ctrl_q), 32'(v & 8'hbf));
  endtask : setctrl
  function automatic logic [7:0] nxt(input logic [7:0] a, input logic [7:0] c);
    if (!c[4] && a == (c[5] ? ODBC_ADDR_INT_FLG : ODBC_ADDR_Z_HIGH)) return ODBC_ADDR_X_LOW;
    return a + 8'h01;
  endfunction : nxt
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    mismatches++;
    results();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check("control reset", 32'(lnk.ctrl_q), 32'(ODBC_REG_RESET));
    for (int c = 0; c < 16; c++) begin
      setctrl(8'(c));
      @(posedge odr_tick);
      @(negedge hclk);
      n = 0;
      do begin
        @(negedge hclk);
        n++;
      end while (odr_tick !== 1'b1);
      check("output period", 32'(n), 32'(2 * ratio[c]));
      check("decimating", 32'(decim_active), 32'(c != 0));
    end
    foreach (rows[i]) begin
      setctrl(rows[i][31:24]);
      check("burst mode", 32'(burst_mode), 32'(rows[i][31]));
      ahb(ODBC_H_COUNT, 1'b1, {26'h0, rows[i][21:16]});
      ahb(ODBC_H_COUNT, 1'b0, 32'h0);
      check("read count", q, {26'h0, rows[i][21:16]});
      check("response", 32'(hresp), 32'h0);
      ahb(ODBC_H_CTRL, 1'b1, 32'h0000_0200);
      repeat (3) @(posedge hclk);
      p = ODBC_ADDR_X_LOW;
      pops = 0;
      check("read start", 32'(lnk.ptr), 32'(p));
      check("reading", 32'(read_active), 32'h1);
      repeat (rows[i][15:8]) begin
        byte_taken <= 1'b1;
        @(negedge hclk) pops += int'(lnk.sample_pop === 1'b1);
        @(posedge hclk) byte_taken <= 1'b0;
        @(negedge hclk) pops += int'(lnk.sample_pop === 1'b1);
        p = nxt(p, rows[i][31:24]);
        check("pointer", 32'(lnk.ptr), 32'(p));
        @(posedge hclk);
      end
      repeat (2) @(negedge hclk) pops += int'(lnk.sample_pop === 1'b1);
      check("samples", 32'(pops), 32'(rows[i][7:0]));
      check("read over", 32'(read_active), 32'h0);
      @(posedge hclk);
      ahb(ODBC_H_STATUS, 1'b0, 32'h0);
      check("status pointer", {24'h0, q[15:8]}, 32'(p));
    end
    ahb(8'h0c, 1'b0, 32'h0);
    check("unmapped read", q, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(negedge hclk);
    check("control second reset", 32'(lnk.ctrl_q), 32'h0);
    check("burst after reset", 32'(burst_mode), 32'h0);
    // release again and make sure the first write after it still lands
    @(posedge hclk);
    hresetn <= 1'b1;
    setctrl(8'h35);
    check("decimating after reset", 32'(decim_active), 32'h1);
    results();
  end
endmodule : tb_top
